// ==== uetr_defs.vh ====
// Constants for the USB endpoint transaction responder.
// Assumes a 25 MHz system clock and a decoded packet-level link interface.
`ifndef UETR_DEFS_VH
`define UETR_DEFS_VH

// ==========================================
// Token kinds from the packet decoder
`define UETR_TOK_OUT 2'h0
`define UETR_TOK_IN 2'h1
`define UETR_TOK_SETUP 2'h2
`define UETR_TOK_SOF 2'h3

// ==========================================
// Endpoint transfer types
`define UETR_TT_CTRL 2'h0
`define UETR_TT_ISO 2'h1
`define UETR_TT_BULK 2'h2
`define UETR_TT_INTR 2'h3

// ==========================================
// Packet to send back
`define UETR_RSP_NONE 3'h0
`define UETR_RSP_ACK 3'h1
`define UETR_RSP_NAK 3'h2
`define UETR_RSP_STALL 3'h3
`define UETR_RSP_DATA 3'h4
`define UETR_RSP_ZLP 3'h5

// ==========================================
// Timing
`define UETR_CLK_HZ 25000000
`define UETR_SUSPEND_US 3000
`define UETR_SUSPEND_CYC ((`UETR_CLK_HZ / 1000000) * `UETR_SUSPEND_US)
`define UETR_ACK_WAIT_CYC 16'h0100

`endif

// ==== uetr_host.sv ====
// Host-side partner: drives decoded tokens, data packets and handshakes.
// Assumes the responder samples on the rising edge of clk_i.
`default_nettype none
module uetr_host (
  // Clock
  input wire logic clk_i,
  // Token, data and handshake towards the responder
  output var logic tok_v_o = 1'b0,
  output var logic [1:0] tok_k_o = 2'h0,
  output var logic [3:0] tok_ep_o = 4'h0,
  output var logic tok_ok_o = 1'b0,
  output var logic dat_v_o = 1'b0,
  output var logic dat_p1_o = 1'b0,
  output var logic dat_ok_o = 1'b0,
  output var logic [10:0] dat_len_o = 11'h000,
  output var logic ack_o = 1'b0,
  output var logic tmo_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Transfers; released token and data fields show inverted values, handshake lines return to 0
  task automatic tok(input logic [1:0] k, input logic [3:0] ep, input logic ok);
    @(posedge clk_i) #1;
    {tok_v_o, tok_k_o, tok_ep_o, tok_ok_o} = {1'b1, k, ep, ok};
    @(posedge clk_i) #1;
    {tok_v_o, tok_k_o, tok_ep_o, tok_ok_o} = {1'b0, ~k, ~ep, ~ok};
  endtask
  task automatic dat(input logic p1, input logic [10:0] len, input logic ok);
    @(posedge clk_i) #1;
    {dat_v_o, dat_p1_o, dat_len_o, dat_ok_o} = {1'b1, p1, len, ok};
    @(posedge clk_i) #1;
    {dat_v_o, dat_p1_o, dat_len_o, dat_ok_o} = {1'b0, ~p1, ~len, ~ok};
  endtask
  // Timeout stands for a lost ACK
  task automatic hs(input logic a);
    @(posedge clk_i) #1;
    {ack_o, tmo_o} = {a, ~a};
    @(posedge clk_i) #1;
    {ack_o, tmo_o} = 2'h0;
  endtask
endmodule // uetr_host
`default_nettype wire

// ==== uetr_idle_timer.v ====
// Bus idle timer: flags suspend after a continuous idle stretch.
// Assumes bus_active_i is already synchronous to clk_i.
`default_nettype none

module uetr_idle_timer #(
  parameter integer IDLE_CYCLES = 75000
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bus state
  input wire bus_active_i,
  // Result
  output reg idle_reached_o
);

  reg [31:0] count;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= 32'h0;
      idle_reached_o <= 1'b0;
    end else if (bus_active_i) begin
      count <= 32'h0;
      idle_reached_o <= 1'b0;
    end else if (count >= IDLE_CYCLES - 1) begin
      idle_reached_o <= 1'b1;
    end else begin
      count <= count + 32'h1;
    end
  end

endmodule // uetr_idle_timer

`default_nettype wire

// ==== uetr_resp_asserts.sv ====
// Checker for the responder: port-level timing relations.
// Assumes it is bound to uetr_responder and sees its ports only.
`default_nettype none
`include "uetr_defs.vh"
module uetr_resp_asserts #(
  parameter integer NUM_EP = 5
) (
  // Clock, reset, inputs, and the reply endpoint output
  input wire clk_i, rst_i, tok_valid_i, tok_crc_ok_i, hs_ack_i,
  input wire [1:0] tok_kind_i,
  input wire [3:0] tok_ep_i, rsp_ep_o,
  input wire [2*NUM_EP-1:0] ep_type_i,
  input wire [NUM_EP-1:0] ep_stall_i, in_ready_i,
  // Outputs
  input wire rsp_valid_o, rsp_pid1_o, out_commit_o, in_release_o,
  input wire suspend_evt_o, reset_evt_o, suspended_o,
  input wire [2:0] rsp_kind_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Bulk or interrupt types share bit 1
  wire tin = tok_valid_i && tok_crc_ok_i && tok_kind_i == `UETR_TOK_IN;
  wire tbk = ep_type_i[{tok_ep_i, 1'b1}];
  wire tst = ep_stall_i[tok_ep_i];
  bad_tok_quiet_a: assert property (tok_valid_i && !tok_crc_ok_i |=>
    (!rsp_valid_o && !out_commit_o) [*4]) else $error("reply to corrupted token");
  in_data_a: assert property (tin && tbk && !tst && in_ready_i[tok_ep_i] |=>
    rsp_valid_o && rsp_kind_o == `UETR_RSP_DATA) else $error("no data for IN");
  in_nak_a: assert property (tin && tbk && !tst && !in_ready_i[tok_ep_i] |=>
    rsp_valid_o && rsp_kind_o == `UETR_RSP_NAK) else $error("no NAK for empty IN");
  in_stall_a: assert property (tin && tbk && tst |=>
    rsp_valid_o && rsp_kind_o == `UETR_RSP_STALL) else $error("no STALL");
  iso_data0_a: assert property (rsp_valid_o && ep_type_i[{rsp_ep_o, 1'b1} -: 2] == 2'h1 |->
    !rsp_pid1_o && rsp_kind_o >= `UETR_RSP_DATA) else $error("iso reply wrong");
  release_ack_a: assert property (in_release_o |-> $past(hs_ack_i) ||
    (rsp_valid_o && ep_type_i[{rsp_ep_o, 1'b1} -: 2] == 2'h1))
    else $error("release without ACK");
  commit_ack_a: assert property (out_commit_o && rsp_valid_o |-> rsp_kind_o == `UETR_RSP_ACK)
    else $error("commit without ACK");
  suspend_flag_a: assert property (suspend_evt_o |-> ##[0:1] suspended_o)
    else $error("suspend flag missing");
  reset_order_a: assert property (reset_evt_o |-> !suspended_o && !$past(suspended_o))
    else $error("reset reported in suspend");
endmodule // uetr_resp_asserts
bind uetr_responder uetr_resp_asserts #(.NUM_EP(NUM_EP)) i_uetr_resp_asserts (.clk_i(clk_i),
  .rst_i(rst_i), .tok_valid_i(tok_valid_i), .tok_crc_ok_i(tok_crc_ok_i), .hs_ack_i(hs_ack_i),
  .tok_kind_i(tok_kind_i), .tok_ep_i(tok_ep_i), .rsp_ep_o(rsp_ep_o), .ep_type_i(ep_type_i),
  .ep_stall_i(ep_stall_i), .in_ready_i(in_ready_i), .rsp_valid_o(rsp_valid_o),
  .rsp_pid1_o(rsp_pid1_o), .out_commit_o(out_commit_o), .in_release_o(in_release_o),
  .suspend_evt_o(suspend_evt_o), .reset_evt_o(reset_evt_o), .suspended_o(suspended_o),
  .rsp_kind_o(rsp_kind_o));
`default_nettype wire

// ==== uetr_responder.v ====
// USB endpoint transaction responder: picks the reply packet for each token.
// Assumes a packet decoder upstream and packet encoder downstream, same clock.
//
// Overview of operation
// - Control transfers run only on endpoint zero.
// - Control read: IN data, OUT zero-length status.
// - Control write/no-data status: answer IN with ZLP.
// - Bulk IN with FIFO data sends data.
// - Toggle data PID after host ACK.
// - Corrupted bulk/interrupt token gets no reply.
// - No ACK: resend same data, same PID.
// - Stalled non-isochronous endpoint answers STALL, but still ACKs SETUP.
// - Empty bulk/interrupt IN FIFO answers NAK.
// - Clean OUT data with valid PID gets ACK.
// - Oversized bulk OUT packet answers STALL.
// - Sequence mismatch on bulk OUT still ACKs.
// - OUT FIFO lacking room answers NAK.
// - Isochronous: no handshake, always DATA0.
// - Corrupted isochronous IN token sends nothing.
// - Empty isochronous IN FIFO sends ZLP.
// - Isochronous OUT accepts errored data, flags it.
// - Corrupted isochronous OUT token drops data.
// - Oversize or no-room isochronous OUT drops data.
// - Interrupt endpoints behave exactly like bulk.
// - No device state sequencing; events only.
// - Suspend after 3ms idle; activity resumes.
// - Reset in suspend: resume first, then reset.
// - Host sends start-of-frame every 1ms.
`default_nettype none
`include "uetr_defs.vh"

module uetr_responder #(
  parameter integer NUM_EP = 5,
  parameter integer SUSPEND_CYCLES = `UETR_SUSPEND_CYC
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Token from decoder
  input wire tok_valid_i,
  input wire [1:0] tok_kind_i,
  input wire [3:0] tok_ep_i,
  input wire tok_crc_ok_i,
  // OUT/SETUP data packet from decoder
  input wire data_valid_i,
  input wire data_pid1_i,
  input wire data_pid_ok_i,
  input wire data_crc_ok_i,
  input wire data_stuff_ok_i,
  input wire [10:0] data_len_i,
  // Handshake from host after IN data
  input wire hs_ack_i,
  input wire hs_timeout_i,
  // Endpoint configuration, one slice per endpoint
  input wire [2*NUM_EP-1:0] ep_type_i,
  input wire [NUM_EP-1:0] ep_stall_i,
  input wire [11*NUM_EP-1:0] ep_maxp_i,
  // FIFO state, one slice per endpoint
  input wire [NUM_EP-1:0] in_ready_i,
  input wire [11*NUM_EP-1:0] out_room_i,
  // Control status stage flag from software
  input wire ctrl_status_in_i,
  // Bus line state, asynchronous
  input wire bus_active_i,
  input wire bus_reset_i,
  // Reply to encoder
  output reg rsp_valid_o,
  output reg [2:0] rsp_kind_o,
  output reg rsp_pid1_o,
  output reg [3:0] rsp_ep_o,
  // FIFO commands
  output reg out_commit_o,
  output reg out_drop_o,
  output reg in_release_o,
  output reg iso_err_o,
  // Events to software
  output reg setup_evt_o,
  output reg sof_evt_o,
  output reg suspend_evt_o,
  output reg resume_evt_o,
  output reg reset_evt_o,
  output reg suspended_o
);

  // ==========================================
  // Transaction state machine
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT_DATA = 2'h1;
  localparam [1:0] ST_WAIT_HS = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [3:0] cur_ep;
  reg cur_setup;
  reg cur_tok_ok;
  reg [NUM_EP-1:0] in_tog;
  reg [NUM_EP-1:0] out_tog;
  reg [15:0] hs_count;

  // Two-flop synchronisers for line state
  reg act_s1, act_s2, rst_s1, rst_s2, rst_s3;

  wire idle_reached;
  wire ep_ok = (tok_ep_i < NUM_EP);

  // ==========================================
  // Per-endpoint field selection
  wire [1:0] tok_type [0:NUM_EP-1];
  wire [10:0] ep_maxp [0:NUM_EP-1];
  wire [10:0] ep_room [0:NUM_EP-1];

  genvar g;
  generate
    for (g = 0; g < NUM_EP; g = g + 1) begin : g_ep
      // Endpoint zero is forced to control
      assign tok_type[g] = (g == 0) ? `UETR_TT_CTRL : ep_type_i[2*g+1:2*g];
      assign ep_maxp[g] = ep_maxp_i[11*g+10:11*g];
      assign ep_room[g] = out_room_i[11*g+10:11*g];
    end
  endgenerate

  wire [2:0] tok_idx = tok_ep_i[2:0];
  wire [2:0] cur_idx = cur_ep[2:0];
  wire [1:0] t_type = tok_type[tok_idx];
  wire [1:0] c_type = tok_type[cur_idx];
  // Interrupt endpoints take the bulk path unchanged
  wire c_iso = (c_type == `UETR_TT_ISO);
  wire t_iso = (t_type == `UETR_TT_ISO);
  wire data_clean = data_crc_ok_i & data_stuff_ok_i;

  // ==========================================
  // Synchronisers
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_s1 <= 1'b0;
      act_s2 <= 1'b0;
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
      rst_s3 <= 1'b0;
    end else begin
      act_s1 <= bus_active_i;
      act_s2 <= act_s1;
      rst_s1 <= bus_reset_i;
      rst_s2 <= rst_s1;
      rst_s3 <= rst_s2;
    end
  end

  uetr_idle_timer #(
    .IDLE_CYCLES(SUSPEND_CYCLES)
  ) u_idle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    // Reset signalling is not idle; stops a re-suspend right after wake-up
    .bus_active_i(act_s2 | rst_s2),
    .idle_reached_o(idle_reached)
  );

  // ==========================================
  // Suspend, resume and bus reset events
  // Hardware only reports; software moves the device state
  reg reset_pending;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      suspended_o <= 1'b0;
      suspend_evt_o <= 1'b0;
      resume_evt_o <= 1'b0;
      reset_evt_o <= 1'b0;
      reset_pending <= 1'b0;
    end else begin
      suspend_evt_o <= 1'b0;
      resume_evt_o <= 1'b0;
      reset_evt_o <= 1'b0;
      if (suspended_o) begin
        if (act_s2 | rst_s2) begin
          // Resume is always reported before a pending reset
          suspended_o <= 1'b0;
          resume_evt_o <= 1'b1;
          reset_pending <= rst_s2;
        end
      end else if (reset_pending) begin
        reset_pending <= 1'b0;
        reset_evt_o <= 1'b1;
      end else if (rst_s2 & ~rst_s3) begin
        reset_evt_o <= 1'b1;
      end else if (idle_reached) begin
        suspended_o <= 1'b1;
        suspend_evt_o <= 1'b1;
      end
    end
  end

  // ==========================================
  // Transaction sequencing
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (tok_valid_i & tok_crc_ok_i & ep_ok & (tok_kind_i == `UETR_TOK_IN) &
            in_ready_i[tok_idx] & ~ep_stall_i[tok_idx] & ~t_iso)
          next_state = ST_WAIT_HS;
        else if (tok_valid_i & (tok_kind_i != `UETR_TOK_IN) &
                 (tok_kind_i != `UETR_TOK_SOF))
          next_state = ST_WAIT_DATA;
      end
      ST_WAIT_DATA: begin
        if (data_valid_i)
          next_state = ST_IDLE;
      end
      ST_WAIT_HS: begin
        if (hs_ack_i | hs_timeout_i | (hs_count == `UETR_ACK_WAIT_CYC))
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cur_ep <= 4'h0;
      cur_setup <= 1'b0;
      cur_tok_ok <= 1'b0;
      in_tog <= {NUM_EP{1'b0}};
      out_tog <= {NUM_EP{1'b0}};
      hs_count <= 16'h0;
      rsp_valid_o <= 1'b0;
      rsp_kind_o <= `UETR_RSP_NONE;
      rsp_pid1_o <= 1'b0;
      rsp_ep_o <= 4'h0;
      out_commit_o <= 1'b0;
      out_drop_o <= 1'b0;
      in_release_o <= 1'b0;
      iso_err_o <= 1'b0;
      setup_evt_o <= 1'b0;
      sof_evt_o <= 1'b0;
    end else begin
      state <= next_state;
      rsp_valid_o <= 1'b0;
      out_commit_o <= 1'b0;
      out_drop_o <= 1'b0;
      in_release_o <= 1'b0;
      setup_evt_o <= 1'b0;
      sof_evt_o <= 1'b0;
      hs_count <= (state == ST_WAIT_HS) ? hs_count + 16'h1 : 16'h0;
      if (rst_s2 & ~rst_s3) begin
        in_tog <= {NUM_EP{1'b0}};
        out_tog <= {NUM_EP{1'b0}};
      end
      case (state)
        ST_IDLE: begin
          if (tok_valid_i) begin
            cur_ep <= tok_ep_i;
            cur_setup <= (tok_kind_i == `UETR_TOK_SETUP);
            cur_tok_ok <= tok_crc_ok_i & ep_ok;
            rsp_ep_o <= tok_ep_i;
            if (tok_kind_i == `UETR_TOK_SOF) begin
              sof_evt_o <= tok_crc_ok_i;
            end else if (tok_kind_i == `UETR_TOK_IN & tok_crc_ok_i & ep_ok) begin
              rsp_valid_o <= 1'b1;
              if (t_iso) begin
                // Isochronous IN never handshakes, always DATA0
                rsp_pid1_o <= 1'b0;
                rsp_kind_o <= in_ready_i[tok_idx] ? `UETR_RSP_DATA
                                                  : `UETR_RSP_ZLP;
                in_release_o <= in_ready_i[tok_idx];
              end else if (ep_stall_i[tok_idx]) begin
                rsp_kind_o <= `UETR_RSP_STALL;
              end else if (in_ready_i[tok_idx]) begin
                // Same toggle on a resend until ACK arrives
                rsp_kind_o <= `UETR_RSP_DATA;
                rsp_pid1_o <= in_tog[tok_idx];
              end else if (tok_idx == 3'h0 & ctrl_status_in_i) begin
                rsp_kind_o <= `UETR_RSP_ZLP;
                rsp_pid1_o <= 1'b1;
              end else begin
                rsp_kind_o <= `UETR_RSP_NAK;
              end
            end
            // Corrupted IN tokens fall through silently
          end
        end
        ST_WAIT_DATA: begin
          if (data_valid_i) begin
            if (!cur_tok_ok) begin
              out_drop_o <= 1'b1;
            end else if (c_iso & ~cur_setup) begin
              // Errored content still kept, only flagged
              iso_err_o <= ~data_clean;
              if ((data_len_i > ep_maxp[cur_idx]) | (data_len_i > ep_room[cur_idx]))
                out_drop_o <= 1'b1;
              else
                out_commit_o <= 1'b1;
            end else if (data_clean & data_pid_ok_i) begin
              rsp_valid_o <= 1'b1;
              if (cur_setup) begin
                // Setup always taken, even when stalled; sets ep0 toggles to 1
                rsp_kind_o <= `UETR_RSP_ACK;
                out_commit_o <= 1'b1;
                setup_evt_o <= 1'b1;
                in_tog[0] <= 1'b1;
                out_tog[0] <= 1'b1;
              end else if (ep_stall_i[cur_idx]) begin
                rsp_kind_o <= `UETR_RSP_STALL;
                out_drop_o <= 1'b1;
              end else if (data_len_i > ep_maxp[cur_idx]) begin
                rsp_kind_o <= `UETR_RSP_STALL;
                out_drop_o <= 1'b1;
              end else if (data_pid1_i != out_tog[cur_idx]) begin
                // Duplicate of a packet already taken
                rsp_kind_o <= `UETR_RSP_ACK;
                out_drop_o <= 1'b1;
              end else if (data_len_i > ep_room[cur_idx]) begin
                rsp_kind_o <= `UETR_RSP_NAK;
                out_drop_o <= 1'b1;
              end else begin
                // Zero-length status OUT on ep0 lands here too
                rsp_kind_o <= `UETR_RSP_ACK;
                out_commit_o <= 1'b1;
                out_tog[cur_idx] <= ~out_tog[cur_idx];
              end
            end else begin
              out_drop_o <= 1'b1;
            end
          end
        end
        ST_WAIT_HS: begin
          if (hs_ack_i) begin
            in_tog[cur_idx] <= ~in_tog[cur_idx];
            in_release_o <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

endmodule // uetr_responder

`default_nettype wire

// ==== usb_endpoint_transaction_responder_tb.sv ====
// Self-checking bench for the endpoint transaction responder.
// Assumes the host model and checker are compiled first.
`default_nettype none
`include "uetr_defs.vh"
module usb_endpoint_transaction_responder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ep0 ctrl, ep1 bulk, ep2 intr, ep3 iso, ep4 bulk
  localparam logic [9:0] TYPES = 10'h278;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic csi = 1'b0;
  logic pok = 1'b1;
  logic sok = 1'b1;
  logic act = 1'b1;
  logic brst = 1'b0;
  logic [4:0] stall = 5'h00;
  logic [4:0] rdy = 5'h00;
  logic [54:0] room = {5{11'h040}};
  logic [54:0] maxp = {5{11'h040}};
  logic tv, tok_ok, dv, dp1, dok, ack, tmo, rv, rp1, commit, rel, ierr, susp;
  logic drop, setup, sof, sevt, revt, bevt;
  logic [3:0] rep;
  logic [1:0] tk;
  logic [3:0] tep;
  logic [10:0] dlen;
  logic [2:0] rk;
  int err_count = 0;
  int compares = 0;
  int n_commit = 0;
  int n_rel = 0;
  always #20 clk_i = ~clk_i;
  uetr_host i_uetr_host (.clk_i(clk_i), .tok_v_o(tv), .tok_k_o(tk), .tok_ep_o(tep),
    .tok_ok_o(tok_ok), .dat_v_o(dv), .dat_p1_o(dp1), .dat_ok_o(dok), .dat_len_o(dlen),
    .ack_o(ack), .tmo_o(tmo));
  uetr_responder #(.NUM_EP(5), .SUSPEND_CYCLES(50)) i_uetr_responder (.clk_i(clk_i),
    .rst_i(rst_i), .tok_valid_i(tv), .tok_kind_i(tk), .tok_ep_i(tep), .tok_crc_ok_i(tok_ok),
    .data_valid_i(dv), .data_pid1_i(dp1), .data_pid_ok_i(pok), .data_crc_ok_i(dok),
    .data_stuff_ok_i(sok), .data_len_i(dlen), .hs_ack_i(ack), .hs_timeout_i(tmo),
    .ep_type_i(TYPES), .ep_stall_i(stall), .ep_maxp_i(maxp), .in_ready_i(rdy),
    .out_room_i(room), .ctrl_status_in_i(csi), .bus_active_i(act), .bus_reset_i(brst),
    .rsp_valid_o(rv), .rsp_kind_o(rk), .rsp_pid1_o(rp1), .rsp_ep_o(rep), .out_commit_o(commit),
    .out_drop_o(drop), .in_release_o(rel), .iso_err_o(ierr), .setup_evt_o(setup),
    .sof_evt_o(sof), .suspend_evt_o(sevt), .resume_evt_o(revt), .reset_evt_o(bevt),
    .suspended_o(susp));
  always @(posedge clk_i) begin
    if (commit === 1'b1) n_commit++;
    if (rel === 1'b1) n_rel++;
  end
  // ==========================================
  // Helpers
  task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // Waits a bounded span; no reply reads as kind 0
  task automatic rsp(input logic [2:0] k, input logic p);
    int i;
    for (i = 0; i < 6 && rv !== 1'b1; i++) @(posedge clk_i) #1;
    chk("reply kind", 11'(k), (rv === 1'b1) ? 11'(rk) : 11'h000);
    if (k >= `UETR_RSP_DATA) chk("reply pid", 11'(p), 11'(rp1));
  endtask
  // ==========================================
  // Scenarios
  task automatic t_bulk_in(input int ep);
    int r;
    r = n_rel;
    rdy[ep] = 1'b1;
    i_uetr_host.tok(`UETR_TOK_IN, 4'(ep), 1'b1);
    rsp(`UETR_RSP_DATA, 1'b0);
    chk("reply ep", 11'(ep), 11'(rep));
    i_uetr_host.hs(1'b0);
    i_uetr_host.tok(`UETR_TOK_IN, 4'(ep), 1'b1);
    rsp(`UETR_RSP_DATA, 1'b0);
    i_uetr_host.hs(1'b1);
    i_uetr_host.tok(`UETR_TOK_IN, 4'(ep), 1'b1);
    rsp(`UETR_RSP_DATA, 1'b1);
    i_uetr_host.hs(1'b1);
    // Release pulse is counted one edge later
    @(posedge clk_i) #1;
    chk("releases", 11'(r + 2), 11'(n_rel));
    rdy[ep] = 1'b0;
    i_uetr_host.tok(`UETR_TOK_IN, 4'(ep), 1'b1);
    rsp(`UETR_RSP_NAK, 1'b0);
    i_uetr_host.tok(`UETR_TOK_IN, 4'(ep), 1'b0);
    rsp(`UETR_RSP_NONE, 1'b0);
    stall[ep] = 1'b1;
    i_uetr_host.tok(`UETR_TOK_IN, 4'(ep), 1'b1);
    rsp(`UETR_RSP_STALL, 1'b0);
    stall[ep] = 1'b0;
  endtask
  task automatic t_bulk_out;
    int c;
    c = n_commit;
    i_uetr_host.tok(`UETR_TOK_OUT, 4'h1, 1'b1);
    i_uetr_host.dat(1'b0, 11'h040, 1'b1);
    rsp(`UETR_RSP_ACK, 1'b0);
    i_uetr_host.tok(`UETR_TOK_OUT, 4'h1, 1'b1);
    i_uetr_host.dat(1'b0, 11'h008, 1'b1);
    rsp(`UETR_RSP_ACK, 1'b0);
    chk("dup drop", 11'h001, 11'(drop));
    chk("commits", 11'(c + 1), 11'(n_commit));
    i_uetr_host.tok(`UETR_TOK_OUT, 4'h1, 1'b1);
    i_uetr_host.dat(1'b1, 11'h041, 1'b1);
    rsp(`UETR_RSP_STALL, 1'b0);
    room[21:11] = 11'h010;
    i_uetr_host.tok(`UETR_TOK_OUT, 4'h1, 1'b1);
    i_uetr_host.dat(1'b1, 11'h020, 1'b1);
    rsp(`UETR_RSP_NAK, 1'b0);
    room[21:11] = 11'h040;
    pok = 1'b0;
    i_uetr_host.tok(`UETR_TOK_OUT, 4'h1, 1'b1);
    i_uetr_host.dat(1'b1, 11'h008, 1'b1);
    rsp(`UETR_RSP_NONE, 1'b0);
    pok = 1'b1;
    sok = 1'b0;
    i_uetr_host.tok(`UETR_TOK_OUT, 4'h1, 1'b1);
    i_uetr_host.dat(1'b1, 11'h008, 1'b1);
    rsp(`UETR_RSP_NONE, 1'b0);
    sok = 1'b1;
    maxp[21:11] = 11'h008;
    i_uetr_host.tok(`UETR_TOK_OUT, 4'h1, 1'b1);
    i_uetr_host.dat(1'b1, 11'h008, 1'b1);
    rsp(`UETR_RSP_ACK, 1'b0);
    maxp[21:11] = 11'h040;
    @(posedge clk_i) #1;
    chk("good commits", 11'(c + 2), 11'(n_commit));
  endtask
  task automatic t_iso;
    int c;
    c = n_commit;
    rdy[3] = 1'b1;
    i_uetr_host.tok(`UETR_TOK_IN, 4'h3, 1'b1);
    rsp(`UETR_RSP_DATA, 1'b0);
    rdy[3] = 1'b0;
    i_uetr_host.tok(`UETR_TOK_IN, 4'h3, 1'b1);
    rsp(`UETR_RSP_ZLP, 1'b0);
    i_uetr_host.tok(`UETR_TOK_IN, 4'h3, 1'b0);
    rsp(`UETR_RSP_NONE, 1'b0);
    i_uetr_host.tok(`UETR_TOK_OUT, 4'h3, 1'b1);
    i_uetr_host.dat(1'b0, 11'h010, 1'b0);
    rsp(`UETR_RSP_NONE, 1'b0);
    chk("iso commit", 11'(c + 1), 11'(n_commit));
    chk("iso error", 11'h001, 11'(ierr));
    i_uetr_host.tok(`UETR_TOK_OUT, 4'h3, 1'b0);
    i_uetr_host.dat(1'b0, 11'h010, 1'b1);
    rsp(`UETR_RSP_NONE, 1'b0);
    i_uetr_host.tok(`UETR_TOK_OUT, 4'h3, 1'b1);
    i_uetr_host.dat(1'b0, 11'h041, 1'b1);
    rsp(`UETR_RSP_NONE, 1'b0);
    chk("iso drops", 11'(c + 1), 11'(n_commit));
  endtask
  task automatic t_ctrl;
    i_uetr_host.tok(`UETR_TOK_SOF, 4'h0, 1'b1);
    chk("frame event", 11'h001, 11'(sof));
    i_uetr_host.tok(`UETR_TOK_SETUP, 4'h0, 1'b1);
    i_uetr_host.dat(1'b0, 11'h008, 1'b1);
    rsp(`UETR_RSP_ACK, 1'b0);
    chk("setup event", 11'h001, 11'(setup));
    rdy[0] = 1'b1;
    i_uetr_host.tok(`UETR_TOK_IN, 4'h0, 1'b1);
    rsp(`UETR_RSP_DATA, 1'b1);
    i_uetr_host.hs(1'b1);
    rdy[0] = 1'b0;
    i_uetr_host.tok(`UETR_TOK_OUT, 4'h0, 1'b1);
    i_uetr_host.dat(1'b1, 11'h000, 1'b1);
    rsp(`UETR_RSP_ACK, 1'b0);
    csi = 1'b1;
    i_uetr_host.tok(`UETR_TOK_IN, 4'h0, 1'b1);
    rsp(`UETR_RSP_ZLP, 1'b1);
    i_uetr_host.hs(1'b1);
    csi = 1'b0;
  endtask
  // Reset in suspend must wake first
  task automatic t_susp;
    int i;
    act = 1'b0;
    for (i = 0; i < 90 && susp !== 1'b1; i++) @(posedge clk_i) #1;
    chk("suspended", 11'h001, 11'(susp));
    chk("idle span", 11'h001, 11'(i >= 50));
    chk("suspend event", 11'h001, 11'(sevt));
    brst = 1'b1;
    for (i = 0; i < 10 && susp !== 1'b0; i++) @(posedge clk_i) #1;
    chk("resumed", 11'h000, 11'(susp));
    chk("resume event", 11'h001, 11'(revt));
    @(posedge clk_i) #1;
    chk("reset event", 11'h001, 11'(bevt));
    brst = 1'b0;
    act = 1'b1;
    @(posedge clk_i) #1;
    chk("stays awake", 11'h000, 11'(susp));
  endtask
  task automatic close_out;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_bulk_in(1);
    t_bulk_in(2);
    t_bulk_out;
    t_iso;
    t_ctrl;
    t_susp;
    close_out;
  end
endmodule // usb_endpoint_transaction_responder_tb
`default_nettype wire
